// *** qdcc_map.svh ***
// Register offsets, field positions and reset values of the counter block
`ifndef QDCC_MAP_SVH
`define QDCC_MAP_SVH

// Bus widths
`define QDCC_AW 4
`define QDCC_DW 24

// Register offsets
`define QDCC_OFF_CHCFG  4'h0
`define QDCC_OFF_INCTL  4'h1
`define QDCC_OFF_QUAD   4'h2
`define QDCC_OFF_CMD    4'h3
`define QDCC_OFF_PRESET 4'h4
`define QDCC_OFF_LATCH  4'h5
`define QDCC_OFF_ISTAT  4'h6
`define QDCC_OFF_IMASK  4'h7
`define QDCC_OFF_STATUS 4'h8

// Channel configuration fields
`define QDCC_CH_XINV  0
`define QDCC_CH_YINV  1
`define QDCC_CH_ZSTD  2
`define QDCC_CH_ZFUNC 3
`define QDCC_CH_ZGATE 4
`define QDCC_CH_SWAP  5

// Input control fields
`define QDCC_IC_CDIR  0
`define QDCC_IC_FHI   5
`define QDCC_IC_FLO   4
`define QDCC_IC_LOAD  2'h0
`define QDCC_IC_CAPT  2'h2
`define QDCC_IC_GATE  2'h1

// Command bits
`define QDCC_CMD_CLR  0
`define QDCC_CMD_LOAD 1
`define QDCC_CMD_CAPT 2

// Interrupt status bits
`define QDCC_IS_BORROW 0
`define QDCC_IS_MATCH  1
`define QDCC_IS_CARRY  2

// Quadrature multiplication codes
`define QDCC_Q_OFF 2'h0
`define QDCC_Q_X1  2'h1
`define QDCC_Q_X2  2'h2
`define QDCC_Q_X4  2'h3

// Reset values
`define QDCC_RST_CHCFG 6'h00
`define QDCC_RST_INCTL 6'h00
`define QDCC_RST_QUAD  2'h0
`define QDCC_RST_MASK  3'h0

`endif

// *** qdcc_pkg.sv ***
// Types shared by the counter block modules
`default_nettype none
package qdcc_pkg;
`include "qdcc_map.svh"

	// Control input function
	typedef enum logic [2:0] {
		CF_NONE,
		CF_LOAD,
		CF_CAPT,
		CF_RESET,
		CF_GATE
	} qdcc_func_t;

	// Top level state
	typedef struct packed {
		logic [5:0]           chcfg;
		logic [5:0]           inctl;
		logic [1:0]           quad;
		logic [`QDCC_DW-1:0]  cnt;
		logic [`QDCC_DW-1:0]  preset;
		logic [`QDCC_DW-1:0]  latch;
		logic [2:0]           stat;
		logic [2:0]           mask;
		logic                 z_p;
		logic                 dir_up;
		logic                 zlvl;
		logic [`QDCC_DW-1:0]  rdata;
		logic                 irq;
	} qdcc_top_st_t;

	// Synchroniser state
	typedef struct packed {
		logic [2:0] s1;
		logic [2:0] s2;
	} qdcc_sync_st_t;

	// Decoder state
	typedef struct packed {
		logic a_p;
		logic b_p;
	} qdcc_dec_st_t;
endpackage
`default_nettype wire

// *** qdcc_link_if.sv ***
// Signals between the input, decoder and counter modules
`timescale 1ns/1ps
`default_nettype none
interface qdcc_link_if;
	logic       xinv;
	logic       yinv;
	logic       swap;
	logic [1:0] quad;
	logic       cdir;
	logic       xs;
	logic       ys;
	logic       zs;
	logic       inc;
	logic       dec;

	modport top (output xinv, yinv, swap, quad, cdir,
		input zs, inc, dec);
	modport syn (input xinv, yinv, swap, output xs, ys, zs);
	modport dcd (input xs, ys, quad, cdir, output inc, dec);
endinterface
`default_nettype wire

// *** qdcc_sync.sv ***
// Input synchroniser with polarity and swap for the count inputs
`timescale 1ns/1ps
`default_nettype none
module qdcc_sync
	import qdcc_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic x_i,
	input  wire logic y_i,
	input  wire logic z_i,
	qdcc_link_if.syn  lk
);
	qdcc_sync_st_t r_reg;
	qdcc_sync_st_t r_next;
	logic          a;
	logic          b;

	// Two flop chain, the first stage feeds only the second
	always_comb begin
		r_next    = r_reg;
		r_next.s1 = {z_i, y_i, x_i};
		r_next.s2 = r_reg.s1;
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign a = r_reg.s2[0] ^ lk.xinv;
	assign b = r_reg.s2[1] ^ lk.yinv;
	assign lk.xs = lk.swap ? b : a;
	assign lk.ys = lk.swap ? a : b;
	assign lk.zs = r_reg.s2[2];
endmodule // qdcc_sync
`default_nettype wire

// *** qdcc_decode.sv ***
// Count input decoder for quadrature, up/down and count/direction
`timescale 1ns/1ps
`default_nettype none
`include "qdcc_map.svh"
module qdcc_decode
	import qdcc_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic rst_i,
	qdcc_link_if.dcd  lk
);
	qdcc_dec_st_t r_reg;
	qdcc_dec_st_t r_next;
	logic         a_edge;
	logic         b_edge;
	logic         a_rise;
	logic         b_rise;
	logic         up_a;
	logic         up_b;

	assign a_edge = lk.xs ^ r_reg.a_p;
	assign b_edge = lk.ys ^ r_reg.b_p;
	assign a_rise = lk.xs & ~r_reg.a_p;
	assign b_rise = lk.ys & ~r_reg.b_p;
	assign up_a = lk.xs ^ lk.ys;
	assign up_b = ~(lk.xs ^ lk.ys);

	// Previous levels and step pulses
	always_comb begin
		r_next     = r_reg;
		r_next.a_p = lk.xs;
		r_next.b_p = lk.ys;
		lk.inc     = 1'b0;
		lk.dec     = 1'b0;
		case (lk.quad)
			`QDCC_Q_OFF: begin
				if (lk.cdir) begin
					lk.inc = a_rise & ~lk.ys;
					lk.dec = a_rise & lk.ys;
				end else begin
					lk.inc = a_rise & ~b_rise;
					lk.dec = b_rise & ~a_rise;
				end
			end
			`QDCC_Q_X1: begin
				lk.inc = a_edge & ~b_edge & up_a & lk.xs;
				lk.dec = a_edge & ~b_edge & ~up_a & ~lk.xs;
			end
			`QDCC_Q_X2: begin
				lk.inc = a_edge & ~b_edge & up_a;
				lk.dec = a_edge & ~b_edge & ~up_a;
			end
			default: begin
				lk.inc = (a_edge & ~b_edge & up_a)
					| (b_edge & ~a_edge & up_b);
				lk.dec = (a_edge & ~b_edge & ~up_a)
					| (b_edge & ~a_edge & ~up_b);
			end
		endcase
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end
endmodule // qdcc_decode
`default_nettype wire

// *** qdcc_top.sv ***
// Counter channel with control input, registers and interrupt
//
// What this block does
// - Counting mode and control function independent
// - Quadrature: X is phase A, Y phase B
// - Quadrature multiplies rate by 1, 2, 4
// - Mode 00, bit0 clear: X up, Y down
// - Mode 00, bit0 set: X counts, Y direction
// - Quadrature direction from relative input phase
// - Quadrature: polarity flip or swap reverses direction
// - Config 0xx ignores control, counting enabled
// - Load mode: control pulse loads preset
// - Capture mode: control pulse latches counter
// - Captured value always coherent
// - Gate mode: control level stops counting
// - Reset mode: control pulse clears counter
// - Software clear, load and capture commands
// - Interrupt on borrow through zero
// - Interrupt on compare match, both directions
// - Counter, preset, latch are 24 bits
// - Interrupt source selectable borrow, match or carry
//
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "qdcc_map.svh"
module qdcc_top
	import qdcc_pkg::*;
(
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	input  wire logic                x_i,
	input  wire logic                y_i,
	input  wire logic                z_i,
	input  wire logic [`QDCC_AW-1:0] addr_i,
	input  wire logic [`QDCC_DW-1:0] wr_data_i,
	input  wire logic                wr_i,
	input  wire logic                rd_i,
	output logic      [`QDCC_DW-1:0] rd_data_o,
	output logic                     irq_o
);
	qdcc_top_st_t r_reg;
	qdcc_top_st_t r_next;
	qdcc_func_t   func;
	qdcc_link_if  lk ();

	logic                zact;
	logic                zpulse;
	logic                cnt_en;
	logic                step_up;
	logic                step_dn;
	logic                cmd_clr;
	logic                cmd_load;
	logic                cmd_capt;
	logic                do_clr;
	logic                do_load;
	logic                do_capt;
	logic                stepped;
	logic [2:0]          ev;
	logic [2:0]          w1c;
	logic                wsel;
	logic [`QDCC_DW-1:0] zero_w;

	assign zero_w = '0;

	// Input synchroniser
	qdcc_sync u_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.x_i   (x_i),
		.y_i   (y_i),
		.z_i   (z_i),
		.lk    (lk.syn)
	);

	// Count decoder
	qdcc_decode u_decode (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.lk    (lk.dcd)
	);

	// Configuration towards the input path
	assign lk.xinv = r_reg.chcfg[`QDCC_CH_XINV];
	assign lk.yinv = r_reg.chcfg[`QDCC_CH_YINV];
	assign lk.swap = r_reg.chcfg[`QDCC_CH_SWAP];
	assign lk.quad = r_reg.quad;
	assign lk.cdir = r_reg.inctl[`QDCC_IC_CDIR];

	assign zact   = r_reg.chcfg[`QDCC_CH_ZSTD] ? lk.zs : ~lk.zs;
	assign zpulse = zact & ~r_reg.z_p;

	// Control function from channel and input control fields
	always_comb begin
		func = CF_NONE;
		if (!r_reg.chcfg[`QDCC_CH_ZGATE]) begin
			func = CF_NONE;
		end else if (r_reg.chcfg[`QDCC_CH_ZFUNC] &&
			r_reg.inctl[`QDCC_IC_FHI:`QDCC_IC_FLO] == `QDCC_IC_LOAD) begin
			func = CF_LOAD;
		end else if (r_reg.chcfg[`QDCC_CH_ZFUNC] &&
			r_reg.inctl[`QDCC_IC_FHI:`QDCC_IC_FLO] == `QDCC_IC_CAPT) begin
			func = CF_CAPT;
		end else if (!r_reg.chcfg[`QDCC_CH_ZFUNC] &&
			r_reg.inctl[`QDCC_IC_FHI:`QDCC_IC_FLO] == `QDCC_IC_LOAD) begin
			func = CF_RESET;
		end else if (!r_reg.chcfg[`QDCC_CH_ZFUNC] &&
			r_reg.inctl[`QDCC_IC_FHI:`QDCC_IC_FLO] == `QDCC_IC_GATE) begin
			func = CF_GATE;
		end else begin
			func = CF_NONE;
		end
	end

	assign cnt_en  = !(func == CF_GATE && zact);
	assign step_up = cnt_en & lk.inc & ~lk.dec;
	assign step_dn = cnt_en & lk.dec & ~lk.inc;

	assign wsel     = wr_i && addr_i == `QDCC_OFF_CMD;
	assign cmd_clr  = wsel && wr_data_i[`QDCC_CMD_CLR];
	assign cmd_load = wsel && wr_data_i[`QDCC_CMD_LOAD];
	assign cmd_capt = wsel && wr_data_i[`QDCC_CMD_CAPT];

	assign do_clr  = (func == CF_RESET && zpulse) || cmd_clr;
	assign do_load = (func == CF_LOAD && zpulse) || cmd_load;
	assign do_capt = (func == CF_CAPT && zpulse) || cmd_capt;
	assign stepped = (step_up | step_dn) & ~do_clr & ~do_load;

	// Interrupt events from counter steps
	always_comb begin
		ev = 3'h0;
		ev[`QDCC_IS_BORROW] = stepped & step_dn
			& (r_reg.cnt == zero_w);
		ev[`QDCC_IS_CARRY] = stepped & step_up
			& (r_reg.cnt == ~zero_w);
		ev[`QDCC_IS_MATCH] = stepped & (step_up
			? (r_reg.cnt + 1'b1) == r_reg.preset
			: (r_reg.cnt - 1'b1) == r_reg.preset);
	end

	// Write one to clear mask for status
	always_comb begin
		w1c = 3'h0;
		if (wr_i && addr_i == `QDCC_OFF_ISTAT) begin
			w1c = wr_data_i[2:0];
		end
	end

	// Next state of counter, registers and outputs
	always_comb begin
		r_next       = r_reg;
		r_next.z_p   = zact;
		r_next.zlvl  = zact;
		r_next.rdata = '0;
		if (do_clr) begin
			r_next.cnt = '0;
		end else if (do_load) begin
			r_next.cnt = r_reg.preset;
		end else if (step_up) begin
			r_next.cnt = r_reg.cnt + 1'b1;
		end else if (step_dn) begin
			r_next.cnt = r_reg.cnt - 1'b1;
		end
		if (stepped) begin
			r_next.dir_up = step_up;
		end
		if (do_capt) begin
			r_next.latch = r_reg.cnt;
		end
		// Register writes
		if (wr_i) begin
			if (addr_i == `QDCC_OFF_CHCFG) begin
				r_next.chcfg = wr_data_i[5:0];
			end else if (addr_i == `QDCC_OFF_INCTL) begin
				r_next.inctl = wr_data_i[5:0];
			end else if (addr_i == `QDCC_OFF_QUAD) begin
				r_next.quad = wr_data_i[1:0];
			end else if (addr_i == `QDCC_OFF_PRESET) begin
				r_next.preset = wr_data_i;
			end else if (addr_i == `QDCC_OFF_IMASK) begin
				r_next.mask = wr_data_i[2:0];
			end
		end
		// Sticky status, a new event wins over clear
		r_next.stat = (r_reg.stat & ~w1c) | ev;
		r_next.irq = |(r_next.stat & r_next.mask);
		// Read data for the next cycle only
		if (rd_i) begin
			if (addr_i == `QDCC_OFF_CHCFG) begin
				r_next.rdata = {18'h0, r_reg.chcfg};
			end else if (addr_i == `QDCC_OFF_INCTL) begin
				r_next.rdata = {18'h0, r_reg.inctl};
			end else if (addr_i == `QDCC_OFF_QUAD) begin
				r_next.rdata = {22'h0, r_reg.quad};
			end else if (addr_i == `QDCC_OFF_PRESET) begin
				r_next.rdata = r_reg.preset;
			end else if (addr_i == `QDCC_OFF_LATCH) begin
				r_next.rdata = r_reg.latch;
			end else if (addr_i == `QDCC_OFF_ISTAT) begin
				r_next.rdata = {21'h0, r_reg.stat};
			end else if (addr_i == `QDCC_OFF_IMASK) begin
				r_next.rdata = {21'h0, r_reg.mask};
			end else if (addr_i == `QDCC_OFF_STATUS) begin
				r_next.rdata = {21'h0, r_reg.zlvl, cnt_en,
					r_reg.dir_up};
			end else begin
				r_next.rdata = '0;
			end
		end
	end

	// State register
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			r_reg       <= '0;
			r_reg.chcfg <= `QDCC_RST_CHCFG;
			r_reg.inctl <= `QDCC_RST_INCTL;
			r_reg.quad  <= `QDCC_RST_QUAD;
			r_reg.mask  <= `QDCC_RST_MASK;
		end else begin
			r_reg <= r_next;
		end
	end

	assign rd_data_o = r_reg.rdata;
	assign irq_o     = r_reg.irq;
endmodule // qdcc_top
`default_nettype wire

// *** qdcc_enc_model.sv ***
// Encoder and pulse source model driving the count and control pins
`timescale 1ns/1ps
`default_nettype none
module qdcc_enc_model (
	input  wire logic clk_i,
	output logic      x_o,
	output logic      y_o,
	output logic      z_o
);
	logic [1:0] ph;
	// Pins idle low, phase counter at rest
	initial begin
		x_o = 1'b0;
		y_o = 1'b0;
		z_o = 1'b0;
		ph = 2'h0;
	end
	// Keeps every level for six cycles
	task automatic hold();
		repeat (6) @(posedge clk_i);
	endtask
	// Sets one pin: 0 is X, 1 is Y, 2 is Z
	task automatic lev(input int sel, input logic v);
		case (sel)
			0: x_o <= v;
			1: y_o <= v;
			default: z_o <= v;
		endcase
		hold();
	endtask
	task automatic pulse(input int sel);
		lev(sel, 1'b1);
		lev(sel, 1'b0);
	endtask
	// phase order gives direction, one pin changes a step
	task automatic qstep(input logic up);
		ph = up ? ph + 2'h1 : ph - 2'h1;
		x_o <= ph[0] ^ ph[1];
		y_o <= ph[1];
		hold();
	endtask
endmodule // qdcc_enc_model
`default_nettype wire

// *** qdcc_top_asserts.sv ***
// Assertions on the register port and interrupt of the counter block
`timescale 1ns/1ps
`default_nettype none
`include "qdcc_map.svh"
module qdcc_top_asserts (
	input wire logic                clk_i,
	input wire logic                rst_i,
	input wire logic                x_i,
	input wire logic                y_i,
	input wire logic                z_i,
	input wire logic [`QDCC_AW-1:0] addr_i,
	input wire logic [`QDCC_DW-1:0] wr_data_i,
	input wire logic                wr_i,
	input wire logic                rd_i,
	input wire logic [`QDCC_DW-1:0] rd_data_o,
	input wire logic                irq_o
);
	logic [2:0]          mask_reg;
	logic [`QDCC_DW-1:0] preset_reg;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Shadow copies of mask and preset
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			mask_reg <= 3'h0;
			preset_reg <= 24'h0;
		end else if (wr_i && addr_i == `QDCC_OFF_IMASK) begin
			mask_reg <= wr_data_i[2:0];
		end else if (wr_i && addr_i == `QDCC_OFF_PRESET) begin
			preset_reg <= wr_data_i;
		end
	end
	a_rd_idle_zero: assert property (!rd_i |=> rd_data_o == 24'h0)
		else $error("read data not zero outside a read");
	a_unmapped_zero: assert property (rd_i && addr_i > `QDCC_OFF_STATUS
		|=> rd_data_o == 24'h0) else $error("unmapped read not zero");
	a_cmd_reads_zero: assert property (rd_i && addr_i == `QDCC_OFF_CMD
		|=> rd_data_o == 24'h0) else $error("command read not zero");
	a_preset_echo: assert property (rd_i && addr_i == `QDCC_OFF_PRESET
		|=> rd_data_o == $past(preset_reg)) else $error("preset readback");
	a_mask_echo: assert property (rd_i && addr_i == `QDCC_OFF_IMASK
		|=> rd_data_o == {21'h0, $past(mask_reg)}) else $error("mask readback");
	a_ctl_width: assert property (rd_i && addr_i < `QDCC_OFF_QUAD
		|=> rd_data_o[23:6] == 18'h0) else $error("control upper bits set");
	a_quad_width: assert property (rd_i && addr_i == `QDCC_OFF_QUAD
		|=> rd_data_o[23:2] == 22'h0) else $error("quad upper bits set");
	a_stat_width: assert property (rd_i && addr_i == `QDCC_OFF_ISTAT
		|=> rd_data_o[23:3] == 21'h0) else $error("status upper bits set");
	a_irq_needs_mask: assert property (irq_o |-> mask_reg != 3'h0)
		else $error("interrupt with all sources masked");
	a_irq_mask_off: assert property ((wr_i && addr_i == `QDCC_OFF_IMASK
		&& wr_data_i[2:0] == 3'h0) ##1 !(wr_i && addr_i == `QDCC_OFF_IMASK)
		|=> !irq_o) else $error("interrupt stays after masking");
endmodule // qdcc_top_asserts
bind qdcc_top qdcc_top_asserts qdcc_top_asserts_i (.clk_i(clk_i),
	.rst_i(rst_i), .x_i(x_i), .y_i(y_i), .z_i(z_i), .addr_i(addr_i),
	.wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
	.rd_data_o(rd_data_o), .irq_o(irq_o));
`default_nettype wire

// *** testbench.sv ***
// Self-checking testbench for the counter block
`timescale 1ns/1ps
`default_nettype none
`include "qdcc_map.svh"
module testbench;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [3:0]  addr_i = 4'h0;
	logic [23:0] wr_data_i = 24'h0;
	logic        wr_i = 1'b0;
	logic        rd_i = 1'b0;
	logic [23:0] rd_data_o;
	logic        irq_o;
	logic        x_i;
	logic        y_i;
	logic        z_i;
	logic [23:0] pol [3] = '{24'h1, 24'h2, 24'h20};
	int          err_count = 0;
	int          comparisons = 0;
	always #12.5 clk_i = ~clk_i;
	qdcc_enc_model qdcc_enc_model_i (.clk_i(clk_i), .x_o(x_i), .y_o(y_i),
		.z_o(z_i));
	qdcc_top qdcc_top_i (.clk_i(clk_i), .rst_i(rst_i), .x_i(x_i),
		.y_i(y_i), .z_i(z_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
		.wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .irq_o(irq_o));
	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [23:0] d);
		addr_i <= a;
		wr_data_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [3:0] a, input logic [23:0] e);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		@(negedge clk_i);
		chk(rd_data_o, e);
		@(posedge clk_i);
	endtask
	task automatic irq(input logic e);
		@(negedge clk_i);
		chk({23'h0, irq_o}, {23'h0, e});
		@(posedge clk_i);
	endtask
	// Captures the counter by command and reads the latch
	task automatic cnt(input logic [23:0] e);
		wr(`QDCC_OFF_CMD, 24'h4);
		rd(`QDCC_OFF_LATCH, e);
	endtask
	task automatic steps(input int n, input logic up);
		repeat (n) qdcc_enc_model_i.qstep(up);
	endtask
	// Two steps up, then one control pulse from the idle level
	task automatic zcase(input logic [23:0] cf, input logic [23:0] ic,
		input logic idle, input logic [23:0] ec, input logic [23:0] el);
		qdcc_enc_model_i.lev(2, idle);
		wr(`QDCC_OFF_INCTL, ic);
		wr(`QDCC_OFF_CHCFG, cf);
		qdcc_enc_model_i.hold();
		wr(`QDCC_OFF_CMD, 24'h1);
		wr(`QDCC_OFF_CMD, 24'h4);
		steps(2, 1'b1);
		qdcc_enc_model_i.lev(2, !idle);
		qdcc_enc_model_i.lev(2, idle);
		rd(`QDCC_OFF_LATCH, el);
		cnt(ec);
	endtask
	task automatic results();
		$display("comparisons=%0d err_count=%0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		for (int a = 0; a < 16; a++) begin
			if (a != 8) begin
				rd(4'(a), 24'h0);
			end
		end
		// Z idle low is active with inverted polarity, counting enabled
		rd(`QDCC_OFF_STATUS, 24'h6);
		for (int q = 1; q < 4; q++) begin
			wr(`QDCC_OFF_QUAD, 24'(q));
			wr(`QDCC_OFF_CMD, 24'h1);
			steps(4, 1'b1);
			cnt(24'h1 << (q - 1));
		end
		foreach (pol[i]) begin
			wr(`QDCC_OFF_CHCFG, pol[i]);
			qdcc_enc_model_i.hold();
			wr(`QDCC_OFF_CMD, 24'h1);
			steps(4, 1'b1);
			cnt(24'hFFFFFC);
		end
		wr(`QDCC_OFF_CHCFG, 24'h0);
		wr(`QDCC_OFF_QUAD, 24'h0);
		wr(`QDCC_OFF_INCTL, 24'h0);
		qdcc_enc_model_i.hold();
		wr(`QDCC_OFF_CMD, 24'h1);
		repeat (3) qdcc_enc_model_i.pulse(0);
		qdcc_enc_model_i.pulse(1);
		cnt(24'h2);
		wr(`QDCC_OFF_INCTL, 24'h1);
		wr(`QDCC_OFF_CMD, 24'h1);
		repeat (2) qdcc_enc_model_i.pulse(0);
		cnt(24'h2);
		qdcc_enc_model_i.lev(1, 1'b1);
		qdcc_enc_model_i.pulse(0);
		cnt(24'h1);
		qdcc_enc_model_i.lev(1, 1'b0);
		wr(`QDCC_OFF_QUAD, 24'h3);
		wr(`QDCC_OFF_PRESET, 24'h7);
		zcase(24'h1C, 24'h00, 1'b0, 24'h7, 24'h0);
		zcase(24'h18, 24'h00, 1'b1, 24'h7, 24'h0);
		zcase(24'h1C, 24'h20, 1'b0, 24'h2, 24'h2);
		zcase(24'h18, 24'h20, 1'b1, 24'h2, 24'h2);
		zcase(24'h14, 24'h00, 1'b0, 24'h0, 24'h0);
		zcase(24'h10, 24'h00, 1'b1, 24'h0, 24'h0);
		zcase(24'h0C, 24'h00, 1'b0, 24'h2, 24'h0);
		zcase(24'h14, 24'h10, 1'b0, 24'h2, 24'h0);
		qdcc_enc_model_i.lev(2, 1'b1);
		steps(2, 1'b1);
		cnt(24'h2);
		qdcc_enc_model_i.lev(2, 1'b0);
		wr(`QDCC_OFF_CHCFG, 24'h0);
		wr(`QDCC_OFF_ISTAT, 24'h7);
		wr(`QDCC_OFF_CMD, 24'h1);
		steps(1, 1'b0);
		rd(`QDCC_OFF_ISTAT, 24'h1);
		// Step up from all ones sets carry beside the sticky borrow
		steps(1, 1'b1);
		rd(`QDCC_OFF_ISTAT, 24'h5);
		wr(`QDCC_OFF_ISTAT, 24'h7);
		wr(`QDCC_OFF_PRESET, 24'h2);
		wr(`QDCC_OFF_CMD, 24'h1);
		steps(2, 1'b1);
		rd(`QDCC_OFF_ISTAT, 24'h2);
		// Match again while counting down onto the compare value
		wr(`QDCC_OFF_ISTAT, 24'h7);
		steps(1, 1'b1);
		steps(1, 1'b0);
		rd(`QDCC_OFF_ISTAT, 24'h2);
		wr(`QDCC_OFF_IMASK, 24'h1);
		irq(1'b0);
		wr(`QDCC_OFF_IMASK, 24'h2);
		irq(1'b1);
		wr(`QDCC_OFF_IMASK, 24'h0);
		irq(1'b0);
		wr(`QDCC_OFF_ISTAT, 24'h2);
		rd(`QDCC_OFF_ISTAT, 24'h0);
		wr(`QDCC_OFF_CMD, 24'h1);
		wr(`QDCC_OFF_CMD, 24'h2);
		cnt(24'h2);
		wr(`QDCC_OFF_CMD, 24'h1);
		cnt(24'h0);
		results();
	end
	// Cuts a hang short
	initial begin
		repeat (100000) @(posedge clk_i);
		err_count++;
		results();
	end
endmodule // testbench
`default_nettype wire
